// >>> rtl/vds_threshold_config_regs.sv
// Drain-source overcurrent threshold register bank behind the serial register port
//
// Function
// - Phase A threshold register at 0x09, reset 0x99, low code high nibble.
// - Phase B threshold register at 0x0A, reset 0x99, low bits 7-4, high 3-0.
// - Phase C threshold register at 0x0B, reset 0x99, low upper, high lower nibble.
// - Low-side code: 4-bit read/write, default 1001b, sixteen rising voltage steps.
// - High-side code: bits 3-0 read/write, default 1001b (0.75 V), same mapping.
// - Lock engaged by 110b, released by 011b; threshold writes ignored while locked.
`timescale 1ns/1ps
module vds_threshold_config_regs
  import vds_threshold_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_en,
  output logic locked,
  output phase_threshold_type [PHASE_COUNT-1:0] thresholds
);

  // Pin synchronisers: stage 0 is only read by stage 1
  // Edges are seen three clocks late, so each SCLK phase needs four clocks
  logic [2:0] scs_sync_q, scs_sync_d;
  logic [2:0] sclk_sync_q, sclk_sync_d;
  logic [1:0] sdi_sync_q, sdi_sync_d;

  always_comb begin
    scs_sync_d = {scs_sync_q[1:0], scs_n};
    sclk_sync_d = {sclk_sync_q[1:0], sclk};
    sdi_sync_d = {sdi_sync_q[0], sdi};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scs_sync_q <= 3'h7;
      sclk_sync_q <= 3'h0;
      sdi_sync_q <= 2'h0;
    end else begin
      scs_sync_q <= scs_sync_d;
      sclk_sync_q <= sclk_sync_d;
      sdi_sync_q <= sdi_sync_d;
    end
  end

  logic cs_active;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_bit;

  assign cs_active = ~scs_sync_q[1];
  assign cs_fall = ~scs_sync_q[1] & scs_sync_q[2];
  assign cs_rise = scs_sync_q[1] & ~scs_sync_q[2];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign sdi_bit = sdi_sync_q[1];

  // Register storage
  phase_threshold_type [PHASE_COUNT-1:0] regs_q, regs_d;
  logic locked_q, locked_d;
  localparam logic [PHASE_COUNT-1:0][ADDR_WIDTH-1:0] PHASE_OFFSETS =
    {PHASE_C_OFFSET, PHASE_B_OFFSET, PHASE_A_OFFSET};

  // Read mux: unmapped addresses and the unstored lock bits read as zero
  function automatic logic [DATA_WIDTH-1:0] read_data(
    input logic [ADDR_WIDTH-1:0] addr,
    input phase_threshold_type [PHASE_COUNT-1:0] regs,
    input logic lock_state
  );
    logic [DATA_WIDTH-1:0] value;
    value = 8'h00;
    case (addr)
      PHASE_A_OFFSET: value = regs[0];
      PHASE_B_OFFSET: value = regs[1];
      PHASE_C_OFFSET: value = regs[2];
      LOCK_OFFSET: value[LOCK_MSB:LOCK_LSB] = lock_state ? LOCK_ENGAGE : LOCK_RELEASE;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // Frame engine: data sampled on SCLK falling, driven on SCLK rising
  frame_state_type state_q, state_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [FRAME_BITS-1:0] shift_in_q, shift_in_d;
  logic [DATA_WIDTH-1:0] shift_out_q, shift_out_d;
  logic sdo_q, sdo_d;
  logic sdo_en_q, sdo_en_d;
  // One-cycle strobe: a complete write frame has just closed
  logic commit;

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_in_d = shift_in_q;
    shift_out_d = shift_out_q;
    sdo_d = sdo_q;
    // Output enable follows the synchronised select for the whole frame
    sdo_en_d = cs_active;
    commit = 1'b0;
    case (state_q)
      FRAME_IDLE: begin
        // Every frame starts from a clean count and a low data line
        if (cs_fall) begin
          state_d = FRAME_SHIFT;
          bit_cnt_d = 5'h00;
          sdo_d = 1'b0;
        end
      end
      FRAME_SHIFT: begin
        if (cs_rise) begin
          state_d = FRAME_IDLE;
          sdo_d = 1'b0;
          // Short, long or read frames never write
          commit = (bit_cnt_q == FULL_FRAME_COUNT) && !shift_in_q[READ_FLAG_POS];
        end else if (sclk_fall && bit_cnt_q <= FULL_FRAME_COUNT) begin
          // Counting one edge past a full frame lets a long frame be refused
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q < FULL_FRAME_COUNT) begin
            shift_in_d = {shift_in_q[FRAME_BITS-2:0], sdi_bit};
          end
          if (bit_cnt_q == LAST_ADDR_COUNT) begin
            // Address complete: the read value is captured before the data phase
            shift_out_d = read_data({shift_in_q[ADDR_WIDTH-2:0], sdi_bit}, regs_q, locked_q);
          end
        end else if (sclk_rise && bit_cnt_q >= DATA_START_COUNT) begin
          // Read data leaves on rising edges so the master takes it on falling ones
          sdo_d = shift_out_q[DATA_WIDTH-1];
          shift_out_d = {shift_out_q[DATA_WIDTH-2:0], 1'b0};
        end
      end
      default: state_d = FRAME_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= FRAME_IDLE;
      bit_cnt_q <= 5'h00;
      shift_in_q <= 16'h0000;
      shift_out_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_in_q <= shift_in_d;
      shift_out_q <= shift_out_d;
      sdo_q <= sdo_d;
      sdo_en_q <= sdo_en_d;
    end
  end

  // Register update at the end of a full write frame
  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [DATA_WIDTH-1:0] wr_data;
  logic [LOCK_MSB-LOCK_LSB:0] wr_lock_code;
  logic lock_hit;
  wire [PHASE_COUNT-1:0] phase_hit;

  assign wr_addr = shift_in_q[ADDR_MSB:ADDR_LSB];
  assign wr_data = shift_in_q[DATA_WIDTH-1:0];
  assign wr_lock_code = wr_data[LOCK_MSB:LOCK_LSB];
  assign lock_hit = commit && (wr_addr == LOCK_OFFSET);

  // One decoder per phase register; a hit is dropped while the lock is engaged
  for (genvar p = 0; p < PHASE_COUNT; p++) begin : g_phase_hit
    assign phase_hit[p] = commit && !locked_q && (wr_addr == PHASE_OFFSETS[p]);
  end

  // Threshold registers: only a decoded, unlocked write frame changes them
  always_comb begin
    regs_d = regs_q;
    for (int p = 0; p < PHASE_COUNT; p++) begin
      if (phase_hit[p]) begin
        regs_d[p] = wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // All three registers return to their power-on code
      for (int i = 0; i < PHASE_COUNT; i++) begin
        regs_q[i] <= THRESHOLD_RESET;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  // Lock state: codes other than engage and release leave it where it is
  always_comb begin
    locked_d = locked_q;
    if (lock_hit) begin
      if (!locked_q && wr_lock_code == LOCK_ENGAGE) begin
        locked_d = 1'b1;
      end else if (locked_q && wr_lock_code == LOCK_RELEASE) begin
        locked_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked_d;
    end
  end

  // Outputs come straight from their flip-flops
  assign sdo = sdo_q;
  assign sdo_en = sdo_en_q;
  assign locked = locked_q;
  assign thresholds = regs_q;

endmodule

// >>> rtl/vds_threshold_pkg.sv
// Register map, field layout and frame constants for the drain-source threshold bank
package vds_threshold_pkg;
  localparam int FRAME_BITS = 16;
  localparam int READ_FLAG_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_WIDTH = 7;
  localparam int DATA_WIDTH = 8;
  localparam int PHASE_COUNT = 3;
  localparam logic [ADDR_WIDTH-1:0] PHASE_A_OFFSET = 7'h09;
  localparam logic [ADDR_WIDTH-1:0] PHASE_B_OFFSET = 7'h0a;
  localparam logic [ADDR_WIDTH-1:0] PHASE_C_OFFSET = 7'h0b;
  localparam logic [ADDR_WIDTH-1:0] LOCK_OFFSET = 7'h0d;
  localparam logic [DATA_WIDTH-1:0] THRESHOLD_RESET = 8'h99;
  localparam int LOW_SIDE_MSB = 7;
  localparam int LOW_SIDE_LSB = 4;
  localparam int HIGH_SIDE_MSB = 3;
  localparam int HIGH_SIDE_LSB = 0;
  localparam int LOCK_MSB = 7;
  localparam int LOCK_LSB = 5;
  localparam logic [2:0] LOCK_ENGAGE = 3'h6;
  localparam logic [2:0] LOCK_RELEASE = 3'h3;
  localparam logic [4:0] DATA_START_COUNT = 5'h08;
  localparam logic [4:0] LAST_ADDR_COUNT = 5'h07;
  localparam logic [4:0] FULL_FRAME_COUNT = 5'h10;

  typedef struct packed {
    logic [3:0] low_side;
    logic [3:0] high_side;
  } phase_threshold_type;

  typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_type;
endpackage

// >>> sim/tb_vds_threshold_config_regs.sv
// Self-checking bench for the drain-source threshold register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_vds_threshold_config_regs;
  import vds_threshold_pkg::*;
  logic sys_clk = 0, resetn = 0, scs_n = 1, sclk = 0, sdi = 0, sdo, sdo_en, locked;
  phase_threshold_type [PHASE_COUNT-1:0] thresholds;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [7:0] rd;
  logic [7:0] vals [3] = '{8'h0f, 8'hf0, 8'h96};
  vds_threshold_config_regs i_dut (.sys_clk(sys_clk), .resetn(resetn), .scs_n(scs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_en(sdo_en), .locked(locked),
    .thresholds(thresholds));
  always #2.5 sys_clk = ~sys_clk;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Each serial phase spans six system clocks, above the four-clock minimum;
  // data changes with SCLK rising so it stands still at the falling sample edge
  task automatic xfer(input logic [15:0] f, output logic [7:0] r, input int nb = 16);
    r = 8'h00;
    scs_n = 0;
    wait_clk(6);
    for (int k = 0; k < nb; k++) begin
      sclk = 1;
      sdi = (k < 16) ? f[15 - k] : 1'b0;
      wait_clk(6);
      if (k >= 8 && k < 16) r[15 - k] = sdo;
      sclk = 0;
      wait_clk(6);
    end
    scs_n = 1;
    wait_clk(12);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer({1'b0, a, d}, r);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    wait_clk(10);
    for (int i = 0; i < 3; i++) `CHK("reset value", THRESHOLD_RESET, thresholds[i])
    resetn = 1;
    wait_clk(5);
    xfer({1'b1, LOCK_OFFSET, 8'h00}, rd);
    `CHK("lock read unlocked", {LOCK_RELEASE, 5'h00}, rd)
    for (int i = 0; i < 3; i++) begin
      xfer({1'b1, PHASE_A_OFFSET + 7'(i), 8'h00}, rd);
      `CHK("reset readback", THRESHOLD_RESET, rd)
      wr(PHASE_A_OFFSET + 7'(i), vals[i]);
      `CHK("low code", vals[i][7:4], thresholds[i].low_side)
      `CHK("high code", vals[i][3:0], thresholds[i].high_side)
      xfer({1'b1, PHASE_A_OFFSET + 7'(i), 8'h00}, rd);
      `CHK("readback", vals[i], rd)
    end
    wr(LOCK_OFFSET, 8'ha0);
    `CHK("other code unlocked", 1'b0, locked)
    wr(LOCK_OFFSET, {LOCK_ENGAGE, 5'h00});
    `CHK("locked", 1'b1, locked)
    xfer({1'b1, LOCK_OFFSET, 8'h00}, rd);
    `CHK("lock read locked", {LOCK_ENGAGE, 5'h00}, rd)
    wr(LOCK_OFFSET, 8'ha0);
    `CHK("other code locked", 1'b1, locked)
    wr(PHASE_B_OFFSET, 8'h33);
    `CHK("write while locked", vals[1], thresholds[1])
    wr(PHASE_C_OFFSET, 8'h33);
    `CHK("write C while locked", vals[2], thresholds[2])
    wr(LOCK_OFFSET, {LOCK_RELEASE, 5'h00});
    `CHK("unlocked", 1'b0, locked)
    wr(PHASE_B_OFFSET, 8'h33);
    `CHK("write after unlock", 8'h33, thresholds[1])
    xfer({1'b0, PHASE_B_OFFSET, 8'h5a}, rd, 15);
    `CHK("short frame", 8'h33, thresholds[1])
    xfer({1'b0, PHASE_B_OFFSET, 8'h5a}, rd, 17);
    `CHK("long frame", 8'h33, thresholds[1])
    xfer({1'b1, 7'h0e, 8'h00}, rd);
    `CHK("unmapped read", 8'h00, rd)
    wr(LOCK_OFFSET, {LOCK_ENGAGE, 5'h00});
    resetn = 0;
    wait_clk(2);
    `CHK("lock after reset", 1'b0, locked)
    for (int i = 0; i < 3; i++) `CHK("reset again", THRESHOLD_RESET, thresholds[i])
    resetn = 1;
    wait_clk(5);
    xfer({1'b1, PHASE_B_OFFSET, 8'h00}, rd);
    `CHK("readback after reset", THRESHOLD_RESET, rd)
    wrap_up();
  end
endmodule

// >>> sim/vds_threshold_sva.sv
// Assertion checker for the drain-source threshold register bank
`timescale 1ns/1ps
module vds_threshold_sva
  import vds_threshold_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_en,
  input wire logic locked,
  input wire phase_threshold_type [PHASE_COUNT-1:0] thresholds
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence idle_s;
    scs_n [*6];
  endsequence
  sequence frame_s;
    (!scs_n) [*6];
  endsequence
  chk_reset_phase_a: assert property ($rose(resetn) |-> thresholds[0] == THRESHOLD_RESET)
    else $error("phase A reset value wrong");
  chk_reset_phase_b: assert property ($rose(resetn) |-> thresholds[1] == THRESHOLD_RESET)
    else $error("phase B reset value wrong");
  chk_reset_phase_c: assert property ($rose(resetn) |-> thresholds[2] == THRESHOLD_RESET)
    else $error("phase C reset value wrong");
  chk_update_after_frame: assert property ($changed(thresholds) |-> scs_n)
    else $error("threshold changed inside a frame");
  chk_lock_holds: assert property (locked && $past(locked) |-> $stable(thresholds))
    else $error("threshold changed while locked");
  chk_lock_after_frame: assert property ($changed(locked) |-> scs_n)
    else $error("lock changed inside a frame");
  chk_idle_quiet: assert property (idle_s |-> !sdo && !sdo_en)
    else $error("serial output active outside a frame");
  chk_enable_in_frame: assert property (frame_s |-> sdo_en)
    else $error("serial output enable low inside a frame");
endmodule
bind vds_threshold_config_regs vds_threshold_sva i_sva (.sys_clk(sys_clk), .resetn(resetn),
  .scs_n(scs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_en(sdo_en), .locked(locked),
  .thresholds(thresholds));
